// ===== dv/bdda_alu_bench.sv
/*
  Bench for bdda_alu: table of accumulator cases, then memory modes.
  Assumes bdda_alu_chk is bound from its own file.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  errors++; $display("ERROR %s expected %h seen %h", n, e, s); end end

module bdda_alu_bench;
  reg        clk = 1'b0;
  reg        rst_b = 1'b0;
  reg        start = 1'b0;
  reg  [7:0] opcode = 8'h00;
  reg  [7:0] directByte = 8'h00;
  reg  [1:0] bankSelect = 2'h0;
  reg  [7:0] accIn = 8'h00;
  reg        carryIn = 1'b0;
  reg        auxCarryIn = 1'b0;
  reg        overflowIn = 1'b0;
  reg  [7:0] memRdata = 8'h00;
  reg        rdLate = 1'b0;
  wire       busy;
  wire       memRd;
  wire [7:0] memAddr;
  wire       memReadLatch;
  wire       memIndirect;
  wire       memWr;
  wire [7:0] memWdata;
  wire       accWe;
  wire [7:0] accOut;
  wire       flagWe;
  wire       carryOut;
  wire       auxCarryOut;
  wire       overflowOut;
  wire [7:0] adjustAmount;
  wire       done;
  reg  [7:0] mem [0:255];
  reg [27:0] rows [0:11];
  reg [27:0] r;
  int        errors = 0;
  int        tests_run = 0;
  int        i;

  bdda_alu i_dut (.clk(clk), .rst_b(rst_b), .start(start),
    .opcode(opcode), .directByte(directByte), .bankSelect(bankSelect),
    .accIn(accIn), .carryIn(carryIn), .auxCarryIn(auxCarryIn),
    .overflowIn(overflowIn), .memRdata(memRdata), .busy(busy),
    .memRd(memRd), .memAddr(memAddr), .memReadLatch(memReadLatch),
    .memIndirect(memIndirect), .memWr(memWr), .memWdata(memWdata),
    .accWe(accWe), .accOut(accOut), .flagWe(flagWe),
    .carryOut(carryOut), .auxCarryOut(auxCarryOut),
    .overflowOut(overflowOut), .adjustAmount(adjustAmount),
    .done(done));

  always #20 clk = ~clk;

  // ************************************************************
  // data memory: pins of a port read inverted unless latch asked
  // ************************************************************
  always @(negedge clk)
  begin
    rdLate <= memRd;
    if (memRd)
      memRdata <= mem[memAddr] ^ (memAddr[7] && !memReadLatch ? 8'hFF : 8'h00);
    else if (!rdLate)
      memRdata <= ~memRdata;
  end

  always @(posedge clk)
    if (memWr)
      mem[memAddr] <= memWdata;

  task stop_test;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // f is {carry, aux carry, overflow}
  task run(input [7:0] o, d, a, input [1:0] b, input [2:0] f);
    int k;
  begin
    while (busy !== 1'b0)
      @(negedge clk);
    opcode = o;
    directByte = d;
    accIn = a;
    bankSelect = b;
    {carryIn, auxCarryIn, overflowIn} = f;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 8 && done !== 1'b1; k++)
      @(negedge clk);
    `CHK("done", 1'b1, done)
  end
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  // row: opcode, acc, {carry aux ovfl expCarry}, expected acc
  initial
  begin
    rows[0] = 28'hD4BE324; rows[1] = 28'hD4C9129; rows[2] = 28'hD456056;
    rows[3] = 28'hD40940F; rows[4] = 28'hD45A060; rows[5] = 28'hD4A3103;
    rows[6] = 28'hD412972; rows[7] = 28'hD49A100; rows[8] = 28'hD4FA160;
    rows[9] = 28'h1400BFF; rows[10] = 28'h1401400; rows[11] = 28'h148027F;
    mem[8'h30] = 8'h00;
    mem[8'h90] = 8'h5A;
    mem[8'h15] = 8'h10;
    mem[8'h09] = 8'h40;
    mem[8'h40] = 8'h01;
    mem[8'h00] = 8'h41;
    mem[8'h41] = 8'h80;
    repeat (3) @(negedge clk);
    `CHK("busy in reset", 1'b0, busy)
    `CHK("done in reset", 1'b0, done)
    @(negedge clk);
    rst_b = 1'b1;
    $display("reset test finished");
    for (i = 0; i < 12; i++)
    begin
      r = rows[i];
      run(r[27:20], 8'h00, r[19:12], 2'h0, r[11:9]);
      `CHK("accOut", r[7:0], accOut)
      `CHK("carryOut", r[8], carryOut)
      `CHK("flagWe", r[27:20] == 8'hD4, flagWe)
      `CHK("accWe", 1'b1, accWe)
      `CHK("overflowOut", r[9], overflowOut)
      `CHK("auxCarryOut", r[10], auxCarryOut)
      if (r[27:20] == 8'hD4)
        `CHK("adjustAmount", r[7:0] - r[19:12], adjustAmount)
      $display("row %0d finished", i);
    end
    run(8'h15, 8'h30, 8'h00, 2'h0, 3'h0);
    @(negedge clk);
    `CHK("direct 30", 8'hFF, mem[8'h30])
    $display("direct wrap test finished");
    run(8'h15, 8'h90, 8'h00, 2'h0, 3'h4);
    @(negedge clk);
    `CHK("port 90", 8'h59, mem[8'h90])
    $display("port latch test finished");
    run(8'h1D, 8'h00, 8'h00, 2'h2, 3'h0);
    @(negedge clk);
    `CHK("bank reg", 8'h0F, mem[8'h15])
    $display("bank register test finished");
    run(8'h17, 8'h00, 8'h00, 2'h1, 3'h2);
    @(negedge clk);
    `CHK("indirect", 8'h00, mem[8'h40])
    $display("indirect test finished");
    run(8'h16, 8'h00, 8'h00, 2'h0, 3'h0);
    @(negedge clk);
    `CHK("indirect r0", 8'h7F, mem[8'h41])
    $display("indirect pointer zero test finished");
    // unknown opcode must run its six states and touch nothing
    run(8'hA5, 8'h30, 8'h77, 2'h0, 3'h0);
    `CHK("unknown accWe", 1'b0, accWe)
    `CHK("unknown flagWe", 1'b0, flagWe)
    @(negedge clk);
    `CHK("unknown mem", 8'hFF, mem[8'h30])
    $display("unknown opcode test finished");
    stop_test;
  end

  // limit is 2500 cycles, about 350 instructions of seven cycles each
  initial
  begin
    #100000;
    errors++;
    stop_test;
  end
endmodule

// ===== dv/bdda_alu_chk.sv
/*
  Checker for bdda_alu: six-state sequencing, decimal-adjust result
  and flags, decrement write-back, memory read side.
  Assumes it is bound to bdda_alu with ports matched by name.
*/
`timescale 1ns/1ps

module bdda_alu_chk (
  input wire       clk,
  input wire       rst_b,
  input wire       start,
  input wire [7:0] opcode,
  input wire [7:0] directByte,
  input wire [7:0] accIn,
  input wire       carryIn,
  input wire       auxCarryIn,
  input wire       overflowIn,
  input wire [7:0] memRdata,
  input wire       busy,
  input wire       memRd,
  input wire [7:0] memAddr,
  input wire       memReadLatch,
  input wire       memIndirect,
  input wire       memWr,
  input wire [7:0] memWdata,
  input wire       accWe,
  input wire [7:0] accOut,
  input wire       flagWe,
  input wire       carryOut,
  input wire       auxCarryOut,
  input wire       overflowOut,
  input wire [7:0] adjustAmount,
  input wire       done
);
  // ************************************************************
  // captured operands
  // ************************************************************
  reg [7:0] accCap;
  reg [7:0] rdVal;
  reg       carryCap;
  reg       auxCap;
  reg       ovflCap;
  reg       rdSeen;

  // read data is valid one cycle after the pulse
  always @(posedge clk)
  begin
    rdSeen <= memRd;
    if (rdSeen)
      rdVal <= memRdata;
    if (start && !busy)
    begin
      accCap <= accIn;
      carryCap <= carryIn;
      auxCap <= auxCarryIn;
      ovflCap <= overflowIn;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sTake;
    start && !busy;
  endsequence

  sequence sRun;
    busy [*5] ##1 (busy && done);
  endsequence

  a_run_six: assert property (sTake |=> sRun)
    else $error("instruction did not finish in six states");
  a_adj_net: assert property (flagWe |-> accWe && accOut ==
    accCap + adjustAmount && adjustAmount inside
    {8'h00, 8'h06, 8'h60, 8'h66})
    else $error("decimal adjust result not acc plus constant");
  a_carry_sticky: assert property (
    flagWe && carryCap |-> carryOut)
    else $error("decimal adjust cleared carry");
  a_flags_keep: assert property (done |->
    overflowOut == ovflCap && auxCarryOut == auxCap)
    else $error("overflow or aux carry changed");
  a_decr_carry: assert property (
    done && !flagWe |-> carryOut == carryCap)
    else $error("decrement changed carry");
  a_adj_decode: assert property (
    (sTake and opcode == 8'hD4) |-> ##6 flagWe)
    else $error("D4 not run as decimal adjust");
  a_dir_read: assert property (
    (sTake and opcode == 8'h15) |->
    ##2 memRd && memAddr == $past(directByte, 2))
    else $error("direct operand not read");
  a_port_latch: assert property (memRd |-> memReadLatch ==
    (!memIndirect && memAddr inside {8'h80, 8'h90, 8'hA0, 8'hB0}))
    else $error("port latch select wrong");
  a_ptr_read: assert property (
    (sTake and opcode[7:1] == 7'h0B) |->
    ##4 memRd && memIndirect && memAddr == rdVal)
    else $error("indirect target not read through pointer");
  a_decr_write: assert property (memWr |->
    done && memWdata == rdVal - 8'h01)
    else $error("written byte not read value minus one");
  a_acc_decr: assert property (accWe && !flagWe |->
    accOut == accCap - 8'h01)
    else $error("accumulator decrement wrong");
endmodule

bind bdda_alu bdda_alu_chk i_chk (.*);

// ===== verilog/bdda_alu.v
/*
  Decimal-adjust and byte-decrement datapath slice of an 8-bit core.
  Holds the six-state sequencer, the opcode decode, operand fetch
  and write-back for accumulator, bank register, direct and indirect
  operands.
  Assumes a data memory that answers a memRd pulse with memRdata
  valid during the next cycle, and that honours memReadLatch by
  returning an output port's data latch instead of its pins.
  memIndirect marks reads that go to internal RAM only, not the indirect write-back.
*/
// Function
// RULE1 - add six when low nibble above nine or aux carry set
// RULE2 - low-step carry through all bits sets carry, never clears it
// RULE3 - add six to high nibble when carry set or nibble above nine
// RULE4 - high-step carry sets carry; carry marks decimal sum >= 100
// RULE5 - decimal adjust leaves overflow flag unchanged
// RULE6 - decimal adjust completes in one cycle of six states
// RULE7 - net adjustment is 00H, 06H, 60H or 66H
// RULE8 - opcode D4H decodes as accumulator decimal adjust
// RULE9 - decrement subtracts one, 00H wraps to 0FFH
// RULE10 - decrement on accumulator, bank register, direct, indirect
// RULE11 - decrement of an output port reads its data latch
// RULE12 - opcode 14H decodes as accumulator decrement, six states
// RULE13 - opcode 15H plus address byte decrements direct byte
// RULE14 - opcode 16H/17H decrements RAM byte pointed to by R0/R1
// RULE15 - decrement leaves carry, aux carry, overflow unchanged
`timescale 1ns/1ps
`include "bdda_map.vh"

module bdda_alu (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       start,
  input  wire [7:0] opcode,
  input  wire [7:0] directByte,
  input  wire [1:0] bankSelect,
  input  wire [7:0] accIn,
  input  wire       carryIn,
  input  wire       auxCarryIn,
  input  wire       overflowIn,
  input  wire [7:0] memRdata,
  output wire       busy,
  output reg        memRd,
  output reg  [7:0] memAddr,
  output reg        memReadLatch,
  output reg        memIndirect,
  output reg        memWr,
  output reg  [7:0] memWdata,
  output reg        accWe,
  output reg  [7:0] accOut,
  output reg        flagWe,
  output reg        carryOut,
  output reg        auxCarryOut,
  output reg        overflowOut,
  output reg  [7:0] adjustAmount,
  output reg        done
);

  // ****************************************************************
  // states, one per machine state of the instruction
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_S1   = 3'd1;
  localparam [2:0] ST_S2   = 3'd2;
  localparam [2:0] ST_S3   = 3'd3;
  localparam [2:0] ST_S4   = 3'd4;
  localparam [2:0] ST_S5   = 3'd5;
  localparam [2:0] ST_S6   = 3'd6;

  // ****************************************************************
  // functions
  // ****************************************************************
  // output port latches sit in the direct space only
  function isPortAddr;
    input [7:0] addr;
    begin
      isPortAddr = (addr == `BDDA_PORT0_ADDR) |
                   (addr == `BDDA_PORT1_ADDR) |
                   (addr == `BDDA_PORT2_ADDR) |
                   (addr == `BDDA_PORT3_ADDR);
    end
  endfunction

  // bank register address: bank * 8 + register number
  function [7:0] bankRegAddr;
    input [1:0] bank;
    input [2:0] regNum;
    begin
      bankRegAddr = {3'b000, bank, regNum};
    end
  endfunction

  function [2:0] decodeMode;
    input [7:0] op;
    begin
      if (op == `BDDA_OP_DECR_ACC)
        decodeMode = `BDDA_MODE_ACC; // [RULE12]
      else if (op == `BDDA_OP_DECR_DIRECT)
        decodeMode = `BDDA_MODE_DIRECT; // [RULE13]
      else if ((op & `BDDA_OP_DECR_IND_MASK) == `BDDA_OP_DECR_IND_BASE)
        decodeMode = `BDDA_MODE_INDIRECT; // [RULE14]
      else if ((op & `BDDA_OP_DECR_REG_MASK) == `BDDA_OP_DECR_REG_BASE)
        decodeMode = `BDDA_MODE_REG; // [RULE10]
      else
        decodeMode = `BDDA_MODE_NONE;
    end
  endfunction

  // ****************************************************************
  // state and captured instruction
  // ****************************************************************
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] opcode_reg;
  reg [7:0] direct_reg;
  reg [1:0] bank_reg;
  reg [7:0] acc_reg;
  reg       carry_reg;
  reg       auxCarry_reg;
  reg       overflow_reg;
  reg [2:0] mode_reg;
  reg       isAdjust_reg;
  reg [7:0] operand_reg;

  wire [7:0] adjValue;
  wire       adjCarry;
  wire [7:0] adjAmount;
  wire [7:0] decrOperand;
  wire [7:0] decrValue;
  wire       fetchesMem;

  assign busy = (state_reg != ST_IDLE);
  assign fetchesMem = (mode_reg == `BDDA_MODE_REG) |
                      (mode_reg == `BDDA_MODE_DIRECT) |
                      (mode_reg == `BDDA_MODE_INDIRECT);

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  bdda_decimal_adjust uAdjust (
    .accValue      (acc_reg),
    .carryIn       (carry_reg),
    .auxCarryIn    (auxCarry_reg),
    .adjustedValue (adjValue),
    .carryOut      (adjCarry),
    .adjustAmount  (adjAmount)
  );

  // indirect operand arrives in S5; accumulator was captured in S1, register and direct in S3
  assign decrOperand = (mode_reg == `BDDA_MODE_INDIRECT) ? memRdata
                                                         : operand_reg;

  bdda_decrement uDecrement (
    .operand (decrOperand),
    .result  (decrValue)
  );

  // ****************************************************************
  // sequencer: always six states, fixed length simplifies the core
  // ****************************************************************
  always @*
  begin
    case (state_reg)
      ST_IDLE: state_next = start ? ST_S1 : ST_IDLE;
      ST_S1:   state_next = ST_S2;
      ST_S2:   state_next = ST_S3;
      ST_S3:   state_next = ST_S4;
      ST_S4:   state_next = ST_S5;
      ST_S5:   state_next = ST_S6; // [RULE6]
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg    <= ST_IDLE;
      opcode_reg   <= 8'h00;
      direct_reg   <= 8'h00;
      bank_reg     <= 2'h0;
      acc_reg      <= 8'h00;
      carry_reg    <= 1'b0;
      auxCarry_reg <= 1'b0;
      overflow_reg <= 1'b0;
      mode_reg     <= `BDDA_MODE_NONE;
      isAdjust_reg <= 1'b0;
      operand_reg  <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      if ((state_reg == ST_IDLE) && start)
      begin
        opcode_reg   <= opcode;
        direct_reg   <= directByte;
        bank_reg     <= bankSelect;
        acc_reg      <= accIn;
        carry_reg    <= carryIn;
        auxCarry_reg <= auxCarryIn;
        overflow_reg <= overflowIn;
        mode_reg     <= decodeMode(opcode); // [RULE10]
        isAdjust_reg <= (opcode == `BDDA_OP_DECIMAL_ADJUST); // [RULE8]
      end
      if (state_reg == ST_S1)
        operand_reg <= acc_reg;
      else if ((state_reg == ST_S3) && fetchesMem)
        operand_reg <= memRdata;
    end
  end

  // ****************************************************************
  // memory reads: first read in S2, pointer-chased read in S4
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      memRd        <= 1'b0;
      memAddr      <= 8'h00;
      memReadLatch <= 1'b0;
      memIndirect  <= 1'b0;
    end
    else
    begin
      memRd        <= 1'b0;
      memReadLatch <= 1'b0;
      memIndirect  <= 1'b0;
      if (state_reg == ST_S1)
      begin
        if (mode_reg == `BDDA_MODE_REG)
        begin
          memRd   <= 1'b1;
          memAddr <= bankRegAddr(bank_reg, opcode_reg[2:0]); // [RULE10]
        end
        else if (mode_reg == `BDDA_MODE_DIRECT)
        begin
          memRd        <= 1'b1;
          memAddr      <= direct_reg; // [RULE13]
          // read-modify-write must not see the pin levels
          memReadLatch <= isPortAddr(direct_reg); // [RULE11]
        end
        else if (mode_reg == `BDDA_MODE_INDIRECT)
        begin
          memRd   <= 1'b1;
          memAddr <= bankRegAddr(bank_reg, {2'b00, opcode_reg[0]}); // [RULE14]
        end
      end
      else if ((state_reg == ST_S3) && (mode_reg == `BDDA_MODE_INDIRECT))
      begin
        memRd       <= 1'b1;
        memAddr     <= memRdata; // [RULE14]
        memIndirect <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // compute in S5, results stand during S6
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      memWr        <= 1'b0;
      memWdata     <= 8'h00;
      accWe        <= 1'b0;
      accOut       <= 8'h00;
      flagWe       <= 1'b0;
      carryOut     <= 1'b0;
      auxCarryOut  <= 1'b0;
      overflowOut  <= 1'b0;
      adjustAmount <= 8'h00;
      done         <= 1'b0;
    end
    else
    begin
      memWr  <= 1'b0;
      accWe  <= 1'b0;
      flagWe <= 1'b0;
      done   <= 1'b0;
      if (state_reg == ST_S5)
      begin
        done        <= 1'b1; // [RULE6]
        carryOut    <= carry_reg; // [RULE15]
        auxCarryOut <= auxCarry_reg; // [RULE15]
        overflowOut <= overflow_reg; // [RULE5]
        if (isAdjust_reg)
        begin
          accWe        <= 1'b1;
          accOut       <= adjValue; // [RULE7]
          flagWe       <= 1'b1;
          carryOut     <= adjCarry; // [RULE4]
          adjustAmount <= adjAmount; // [RULE7]
        end
        else if (mode_reg == `BDDA_MODE_ACC)
        begin
          accWe  <= 1'b1;
          accOut <= decrValue; // [RULE9]
        end
        else if (fetchesMem)
        begin
          // memAddr still holds the operand address here
          memWr    <= 1'b1;
          memWdata <= decrValue; // [RULE9]
        end
        // decrement raises no flag write at all [RULE15]
      end
    end
  end

endmodule

// ===== verilog/bdda_decimal_adjust.v
/*
  Combinational decimal-adjust unit: corrects an accumulator value
  left by a packed-BCD addition, using carry and auxiliary carry.
  Assumes the caller registers the result and flag.
*/
`timescale 1ns/1ps
`include "bdda_map.vh"

module bdda_decimal_adjust (
  input  wire [7:0] accValue,
  input  wire       carryIn,
  input  wire       auxCarryIn,
  output wire [7:0] adjustedValue,
  output wire       carryOut,
  output wire [7:0] adjustAmount
);

  wire       lowFix;
  wire [8:0] lowSum;
  wire       carryMid;
  wire       highFix;
  wire [8:0] highSum;

  // ****************************************************************
  // low nibble step
  // ****************************************************************
  assign lowFix = (accValue[3:0] > `BDDA_BCD_DIGIT_MAX) | auxCarryIn; // [RULE1]
  assign lowSum = {1'b0, accValue} +
                  {1'b0, (lowFix ? `BDDA_ADJ_LOW : `BDDA_ADJ_NONE)}; // [RULE1]
  // carry only ever gets set here, never cleared
  assign carryMid = carryIn | lowSum[8]; // [RULE2]

  // ****************************************************************
  // high nibble step, looks at the already corrected value
  // ****************************************************************
  assign highFix = carryMid | (lowSum[7:4] > `BDDA_BCD_DIGIT_MAX); // [RULE3]
  assign highSum = {1'b0, lowSum[7:0]} +
                   {1'b0, (highFix ? `BDDA_ADJ_HIGH : `BDDA_ADJ_NONE)}; // [RULE3]
  assign carryOut = carryMid | highSum[8]; // [RULE4]

  assign adjustedValue = highSum[7:0];
  // net effect is one of 00H, 06H, 60H, 66H
  assign adjustAmount = (lowFix ? `BDDA_ADJ_LOW : `BDDA_ADJ_NONE) |
                        (highFix ? `BDDA_ADJ_HIGH : `BDDA_ADJ_NONE); // [RULE7]

endmodule

// ===== verilog/bdda_decrement.v
/*
  Combinational byte decrement with wrap from 00H to 0FFH.
  Assumes the caller selects the operand and registers the result.
*/
`timescale 1ns/1ps

module bdda_decrement (
  input  wire [7:0] operand,
  output wire [7:0] result
);

  // modulo-256 subtract, 00H falls to 0FFH
  assign result = operand - 8'h01; // [RULE9]

endmodule

// ===== verilog/bdda_map.vh
/*
  Constants for the decimal-adjust / decrement datapath slice:
  opcodes, opcode masks, special addresses, BCD correction values
  and the instruction length in states.
  Assumes it is included by bare name from the design files only.
*/
`ifndef BDDA_MAP_VH
`define BDDA_MAP_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define BDDA_OP_DECIMAL_ADJUST   8'hD4
`define BDDA_OP_DECR_ACC         8'h14
`define BDDA_OP_DECR_DIRECT      8'h15
// indirect: 0001 011i, bank register: 0001 1rrr
`define BDDA_OP_DECR_IND_BASE    8'h16
`define BDDA_OP_DECR_IND_MASK    8'hFE
`define BDDA_OP_DECR_REG_BASE    8'h18
`define BDDA_OP_DECR_REG_MASK    8'hF8

// ****************************************************************
// operand modes
// ****************************************************************
`define BDDA_MODE_NONE           3'h0
`define BDDA_MODE_ACC            3'h1
`define BDDA_MODE_REG            3'h2
`define BDDA_MODE_DIRECT         3'h3
`define BDDA_MODE_INDIRECT       3'h4

// ****************************************************************
// output port latch addresses (direct space)
// ****************************************************************
`define BDDA_PORT0_ADDR          8'h80
`define BDDA_PORT1_ADDR          8'h90
`define BDDA_PORT2_ADDR          8'hA0
`define BDDA_PORT3_ADDR          8'hB0

// ****************************************************************
// BCD correction
// ****************************************************************
`define BDDA_BCD_DIGIT_MAX       4'h9
`define BDDA_ADJ_NONE            8'h00
`define BDDA_ADJ_LOW             8'h06
`define BDDA_ADJ_HIGH            8'h60

// ****************************************************************
// timing
// ****************************************************************
`define BDDA_STATES_PER_INSN     6
`define BDDA_STATE_CODE_W        3

`endif
